// File: hw/cbac_consts.svh
// Constants of the bus auxiliary control block
`ifndef CBAC_CONSTS_SVH
`define CBAC_CONSTS_SVH

`define CBAC_SYS_PERIOD_NS      100
`define CBAC_BUS_PERIOD_NS      (2 * `CBAC_SYS_PERIOD_NS)
`define CBAC_HALF_CLK_CYC       1
`define CBAC_EXTDE_DLY_CYC      `CBAC_HALF_CLK_CYC
`define CBAC_IOSTB_DLY_CYC      (2 * `CBAC_HALF_CLK_CYC)
`define CBAC_MATCH_MIN_HALFCLK  3
`define CBAC_MATCH_MIN_NS       (`CBAC_MATCH_MIN_HALFCLK * `CBAC_BUS_PERIOD_NS / 2)
`define CBAC_MATCH_MIN_CYC      ((`CBAC_MATCH_MIN_NS + `CBAC_SYS_PERIOD_NS - 1) / `CBAC_SYS_PERIOD_NS)

`define CBAC_CTL_READS          0
`define CBAC_CTL_WRITES         1
`define CBAC_PIN_WINDOW         0
`define CBAC_PIN_STROBE         1

`define CBAC_BEATS_ONE          5'h01
`define CBAC_BEATS_QUAD_WORD    5'h04
`define CBAC_BEATS_OCT_HALF     5'h08
`define CBAC_BEATS_SIXTEEN_BYTE 5'h10
`define CBAC_IRQ_IDLE           3'h7

`endif

// File: hw/cbac_pkg.sv
// Types shared by the bus auxiliary control block
package cbac_pkg;

    typedef enum logic [1:0] {
        CBAC_PORT_32,
        CBAC_PORT_16,
        CBAC_PORT_8,
        CBAC_PORT_RSVD
    } cbac_port_t;

    typedef enum logic [1:0] {
        CBAC_SZ_BYTE,
        CBAC_SZ_HALF,
        CBAC_SZ_TRI,
        CBAC_SZ_WORD
    } cbac_size_t;

    typedef struct packed {
        logic       brcond_in;
        logic [1:0] strobe_ctl;
        logic [1:0] window_ctl;
        logic       match_hold;
        logic       fair_arb;
        logic       dcache_quad;
        cbac_port_t port_size;
    } cbac_bus_ctl_t;

    typedef struct packed {
        logic       valid;
        logic       instr;
        logic       uncached;
        logic       hit;
        cbac_size_t size;
    } cbac_rd_req_t;

    typedef struct packed {
        logic       issue;
        logic       burst;
        logic [4:0] beats;
    } cbac_rd_plan_t;

endpackage

// File: hw/cbac_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/10ps
module cbac_sync3 #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s1_r  <= INIT;
            s2_r  <= INIT;
            s3_r  <= INIT;
            out_r <= INIT;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Each bit moves only when stages two and three agree
            out_r <= (s3_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
        end
    end

    assign o_sync = out_r;
endmodule

// File: hw/cbac_read_planner.sv
// Decides whether a read reaches the bus and in which form for the port width
`timescale 1ns/10ps
`include "cbac_consts.svh"
module cbac_read_planner (
    input  wire cbac_pkg::cbac_rd_req_t  i_req,
    input  wire cbac_pkg::cbac_port_t    i_port,
    input  wire logic                    i_dcache_quad,
    output cbac_pkg::cbac_rd_plan_t      o_plan
);
    logic block;
    logic [4:0] single;

    always_comb begin
        // Cached hits are served from the caches and never reach the bus
        o_plan.issue = i_req.valid && (i_req.uncached || !i_req.hit);
        // Instruction misses always refill a block, data misses per cache setting
        block = !i_req.uncached && (i_req.instr || i_dcache_quad);
        case (i_port)
            cbac_pkg::CBAC_PORT_16: begin
                single = i_req.size[1] ? 5'h02 : 5'h01;
            end
            cbac_pkg::CBAC_PORT_8: begin
                single = {3'h0, i_req.size} + 5'h01;
            end
            default: begin
                single = `CBAC_BEATS_ONE;
            end
        endcase
        o_plan.burst = block;
        case (i_port)
            cbac_pkg::CBAC_PORT_16: o_plan.beats = block ? `CBAC_BEATS_OCT_HALF : single;
            cbac_pkg::CBAC_PORT_8:  o_plan.beats = block ? `CBAC_BEATS_SIXTEEN_BYTE : single;
            default:                o_plan.beats = block ? `CBAC_BEATS_QUAD_WORD : single;
        endcase
    end
endmodule

// File: hw/cbac_top.sv
// Auxiliary bus control: dual-purpose pins, trace, float, mastership, irq, clock, match pulse
//
// Overview of operation
// - Select bit set makes both dual pins branch inputs, else strobe outputs.
// - Peripheral strobe falls on bus clock falling edge one clock after latch enable.
// - Each strobe fires on reads, writes or both per its control field.
// - Extended window falls on the rising edge half a clock after latch enable.
// - Extended window stays low one clock past the end of read or write.
// - Branch inputs are synchronised and readable by branch instructions.
// - Trace high for cache miss, low for uncached, during read address phase.
// - Trace high for instruction fetch, low for data, for rest of read.
// - Trace carries no meaning during writes and nothing relies on it.
// - Float input low releases every output, clock, match and grant included.
// - External master requests bus with low request; bus reclaimed on release.
// - Grant goes low once the bus is handed to the external master.
// - Fair option clear gives DMA priority; set gives processor equal turns.
// - Synced irq inputs are synchronised here; direct ones arrive already synchronous.
// - Double-rate input clock is halved into the bus reference clock.
// - Timer equal to compare pulses match output low for at least 1.5 clocks.
// - With hold option, match stays low until compare is written.
// - Reset configuration modes are captured in the last reset cycle.
// - Of reads, only uncached ones and cache misses go out on the bus.
// - Instruction misses read blocks; data misses per setting; uncached read single.
// - Read form follows port width: 32, 16 or 8-bit sequences.
// - Latch enable high while the bus carries address and byte enables.
`timescale 1ns/10ps
`include "cbac_consts.svh"
module cbac_top (
    input  wire logic                     I_CLK_SYS,
    input  wire logic                     I_NRST,
    input  wire logic [3:0]               I_RESET_MODES,
    output logic      [3:0]               O_RESET_MODES,
    input  wire logic                     I_CFG_WR,
    input  wire cbac_pkg::cbac_bus_ctl_t  I_BUS_CTL,
    input  wire cbac_pkg::cbac_rd_req_t   I_RD_REQ,
    input  wire logic                     I_WR_REQ,
    output logic                          O_REQ_READY,
    output logic                          O_HIT_DONE,
    input  wire logic                     I_RDCEN_N,
    input  wire logic                     I_ACK_N,
    output logic                          O_ALE,
    output logic                          O_RD_N,
    output logic                          O_WR_N,
    output logic                          O_BURST_N,
    output logic      [4:0]               O_BEATS,
    output logic                          O_TRACE,
    output logic                          O_BUS_OE,
    input  wire logic [1:0]               I_DUAL_PIN,
    output logic      [1:0]               O_DUAL_PIN,
    output logic      [1:0]               O_DUAL_OE,
    output logic      [1:0]               O_BRCOND,
    input  wire logic                     I_FLOAT_ALL_N,
    input  wire logic                     I_MREQ_N,
    output logic                          O_MGNT_N,
    output logic                          O_MGNT_OE,
    input  wire logic [2:0]               I_SYNC_IRQ_N,
    input  wire logic [2:0]               I_DIRECT_IRQ_N,
    output logic      [5:0]               O_IRQ_N,
    output logic                          O_BUS_REF_CLK,
    output logic                          O_BUS_REF_CLK_OE,
    input  wire logic [31:0]              I_TIMER,
    input  wire logic [31:0]              I_COMPARE,
    input  wire logic                     I_CMP_WR,
    output logic                          O_MATCH_N,
    output logic                          O_MATCH_OE
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_TAIL
    } cbac_state_t;

    localparam logic [1:0] MATCH_CYC = 2'(`CBAC_MATCH_MIN_CYC);
    localparam logic [1:0] EXTDE_CYC = 2'(`CBAC_EXTDE_DLY_CYC);
    localparam logic [1:0] IOSTB_CYC = 2'(`CBAC_IOSTB_DLY_CYC);

    cbac_state_t             state_r;
    cbac_pkg::cbac_rd_plan_t plan;
    cbac_pkg::cbac_rd_req_t  req_r;
    logic                    is_rd_r;
    logic [4:0]              beats_left_r;
    logic [1:0]              dcnt_r;
    logic                    ref_clk_r;
    logic                    cfg_done_r;
    logic [3:0]              modes_r;
    logic [1:0]              brcond_sync;
    logic                    mreq_sync_n;
    logic [2:0]              irq_sync_n;
    logic [5:0]              irq_r;
    logic                    grant_r;
    logic                    dma_last_r;
    logic                    core_pending;
    logic                    hit_done_r;
    logic                    ale_r;
    logic                    rd_r;
    logic                    wr_r;
    logic                    burst_r;
    logic [4:0]              beats_r;
    logic                    trace_r;
    logic                    strobe_r;
    logic                    window_r;
    logic                    strobe_en;
    logic                    window_en;
    logic                    float_all;
    logic                    match_r;
    logic [1:0]              match_cnt_r;
    logic                    match_seen_r;
    logic                    equal_now;
    logic                    start_ok;

    cbac_read_planner u_planner (
        .i_req         (I_RD_REQ),
        .i_port        (I_BUS_CTL.port_size),
        .i_dcache_quad (I_BUS_CTL.dcache_quad),
        .o_plan        (plan)
    );
    cbac_sync3 #(.W(2), .INIT(2'h3)) u_sync_brcond (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_async (I_DUAL_PIN),
        .o_sync  (brcond_sync)
    );
    cbac_sync3 #(.W(1), .INIT(1'h1)) u_sync_mreq (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_async (I_MREQ_N),
        .o_sync  (mreq_sync_n)
    );
    cbac_sync3 #(.W(3), .INIT(`CBAC_IRQ_IDLE)) u_sync_irq (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_async (I_SYNC_IRQ_N),
        .o_sync  (irq_sync_n)
    );

    // Float input is itself a pin but must act at once, so it gates enables directly
    assign float_all = !I_FLOAT_ALL_N;
    // Bus reference clock at half the input rate
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            ref_clk_r <= 1'b0;
        end else begin
            ref_clk_r <= !ref_clk_r;
        end
    end

    // Modes are sampled every reset cycle, so the last one before release sticks
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            modes_r <= I_RESET_MODES;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            cfg_done_r <= 1'b0;
        end else if (I_CFG_WR) begin
            cfg_done_r <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            irq_r <= 6'h3F;
        end else begin
            irq_r <= {I_DIRECT_IRQ_N, irq_sync_n};
        end
    end

    // Transactions start only on a rising edge of the reference clock
    assign core_pending = (I_RD_REQ.valid && plan.issue) || I_WR_REQ;
    assign start_ok     = (state_r == ST_IDLE) && !grant_r && !ref_clk_r;

    // Mastership hand-off; fair mode lets a waiting core transfer run between DMA tenures
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            grant_r    <= 1'b0;
            dma_last_r <= 1'b0;
        end else if (grant_r) begin
            if (mreq_sync_n) begin
                grant_r <= 1'b0;
            end
        end else if (!mreq_sync_n && state_r == ST_IDLE) begin
            if (!(I_BUS_CTL.fair_arb && dma_last_r && core_pending)) begin
                grant_r    <= 1'b1;
                dma_last_r <= 1'b1;
            end
        end else if (state_r == ST_ADDR) begin
            dma_last_r <= 1'b0;
        end
    end

    assign O_REQ_READY = start_ok && !(!mreq_sync_n && !(I_BUS_CTL.fair_arb && dma_last_r));
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            hit_done_r <= 1'b0;
        end else begin
            hit_done_r <= O_REQ_READY && I_RD_REQ.valid && !plan.issue;
        end
    end

    // Transaction sequencer
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            state_r      <= ST_IDLE;
            req_r        <= '0;
            is_rd_r      <= 1'b0;
            beats_left_r <= 5'h00;
            dcnt_r       <= 2'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    dcnt_r <= 2'h0;
                    if (O_REQ_READY && I_RD_REQ.valid && plan.issue) begin
                        state_r      <= ST_ADDR;
                        req_r        <= I_RD_REQ;
                        is_rd_r      <= 1'b1;
                        beats_left_r <= plan.beats;
                    end else if (O_REQ_READY && I_WR_REQ) begin
                        state_r      <= ST_ADDR;
                        req_r        <= '0;
                        is_rd_r      <= 1'b0;
                        beats_left_r <= `CBAC_BEATS_ONE;
                    end
                end
                ST_ADDR: begin
                    state_r <= ST_DATA;
                end
                ST_DATA: begin
                    if (dcnt_r != IOSTB_CYC) begin
                        dcnt_r <= dcnt_r + 2'h1;
                    end
                    if (is_rd_r && !I_RDCEN_N) begin
                        beats_left_r <= beats_left_r - 5'h01;
                        if (beats_left_r == 5'h01) begin
                            state_r <= ST_TAIL;
                        end
                    end else if (!is_rd_r && !I_ACK_N) begin
                        state_r <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Primary bus outputs, all registered
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            ale_r   <= 1'b0;
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            burst_r <= 1'b0;
            beats_r <= 5'h00;
        end else begin
            ale_r <= (state_r == ST_IDLE) && O_REQ_READY && core_pending;
            if (state_r == ST_IDLE && O_REQ_READY && I_RD_REQ.valid && plan.issue) begin
                rd_r    <= 1'b1;
                burst_r <= plan.burst;
                beats_r <= plan.beats;
            end else if (state_r == ST_IDLE && O_REQ_READY && I_WR_REQ) begin
                wr_r    <= 1'b1;
                burst_r <= 1'b0;
                beats_r <= `CBAC_BEATS_ONE;
            end else if (state_r == ST_DATA && (is_rd_r ? (!I_RDCEN_N && beats_left_r == 5'h01) : !I_ACK_N)) begin
                rd_r <= 1'b0;
                wr_r <= 1'b0;
            end
        end
    end

    // Writes drive trace low; it means nothing then
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            trace_r <= 1'b0;
        end else if (state_r == ST_IDLE && O_REQ_READY && I_RD_REQ.valid && plan.issue) begin
            trace_r <= !I_RD_REQ.uncached;
        end else if (state_r == ST_ADDR && is_rd_r) begin
            trace_r <= req_r.instr;
        end else if (state_r == ST_IDLE && I_WR_REQ) begin
            trace_r <= 1'b0;
        end
    end

    // Control fields choose reads, writes or both for each strobe
    assign strobe_en = is_rd_r ? I_BUS_CTL.strobe_ctl[`CBAC_CTL_READS] : I_BUS_CTL.strobe_ctl[`CBAC_CTL_WRITES];
    assign window_en = is_rd_r ? I_BUS_CTL.window_ctl[`CBAC_CTL_READS] : I_BUS_CTL.window_ctl[`CBAC_CTL_WRITES];

    // Delays counted from the cycle after the latch enable falls
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            strobe_r <= 1'b0;
        end else if (state_r == ST_DATA && (rd_r | wr_r)) begin
            strobe_r <= strobe_en && (dcnt_r + 2'h1 >= IOSTB_CYC) && (ref_clk_r || strobe_r);
        end else begin
            strobe_r <= strobe_r && state_r == ST_DATA && (rd_r | wr_r);
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            window_r <= 1'b0;
        end else if (state_r == ST_DATA && (dcnt_r + 2'h1 >= EXTDE_CYC)) begin
            window_r <= window_en;
        end else if (state_r == ST_TAIL) begin
            window_r <= window_r;
        end else begin
            window_r <= 1'b0;
        end
    end

    // Dual pins; strobe or window only once software has set up the bus control
    always_comb begin
        O_DUAL_PIN[`CBAC_PIN_STROBE] = !strobe_r;
        O_DUAL_PIN[`CBAC_PIN_WINDOW] = !window_r;
        O_DUAL_OE = (!I_BUS_CTL.brcond_in && cfg_done_r && !float_all && !grant_r) ? 2'h3 : 2'h0;
    end

    assign O_BRCOND = I_BUS_CTL.brcond_in ? brcond_sync : 2'h0;

    // Match pulse: minimum width counted, hold option waits for a compare write
    assign equal_now = (I_TIMER == I_COMPARE);

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            match_r      <= 1'b0;
            match_cnt_r  <= 2'h0;
            match_seen_r <= 1'b0;
        end else begin
            match_seen_r <= equal_now;
            if (equal_now && !match_seen_r) begin
                match_r     <= 1'b1;
                match_cnt_r <= MATCH_CYC - 2'h1;
            end else if (match_cnt_r != 2'h0) begin
                match_cnt_r <= match_cnt_r - 2'h1;
            end else if (I_BUS_CTL.match_hold) begin
                if (I_CMP_WR) begin
                    match_r <= 1'b0;
                end
            end else begin
                match_r <= 1'b0;
            end
        end
    end

    assign O_RESET_MODES    = modes_r;
    assign O_HIT_DONE       = hit_done_r;
    assign O_ALE            = ale_r;
    assign O_RD_N           = !rd_r;
    assign O_WR_N           = !wr_r;
    assign O_BURST_N        = !burst_r;
    assign O_BEATS          = beats_r;
    assign O_TRACE          = trace_r;
    assign O_BUS_OE         = !grant_r && !float_all;
    assign O_MGNT_N         = !grant_r;
    assign O_MGNT_OE        = !float_all;
    assign O_IRQ_N          = irq_r;
    assign O_BUS_REF_CLK    = ref_clk_r;
    assign O_BUS_REF_CLK_OE = !float_all;
    assign O_MATCH_N        = !match_r;
    assign O_MATCH_OE       = !float_all;
endmodule

// File: verification/cbac_mem_model.sv
// Far-side memory model: data strobes for reads, one acknowledge for writes
`timescale 1ns/10ps
module cbac_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [4:0] i_beats,
    input  wire logic [3:0] i_wait,
    output logic            o_rdcen_n,
    output logic            o_ack_n
);
    int n;
    initial begin
        {o_rdcen_n, o_ack_n} = 2'h3;
        forever begin
            @(posedge i_clk);
            #1;
            if (i_rd_n === 1'b0 || i_wr_n === 1'b0) begin
                n = (i_rd_n === 1'b0) ? int'(i_beats) : 1;
                // Address phase first, then the chosen wait states
                repeat (i_wait + 1) @(posedge i_clk);
                #1;
                repeat (n) begin
                    {o_rdcen_n, o_ack_n} = (i_rd_n === 1'b0) ? 2'h1 : 2'h2;
                    @(posedge i_clk);
                    #1;
                end
                {o_rdcen_n, o_ack_n} = 2'h3;
                while (i_rd_n === 1'b0 || i_wr_n === 1'b0) @(posedge i_clk);
            end
        end
    end
endmodule

// File: verification/cbac_top_props.sv
// Concurrent checks on the ports of the auxiliary bus control block
`timescale 1ns/10ps
module cbac_top_props (
    input wire logic                    I_CLK_SYS,
    input wire logic                    I_NRST,
    input wire cbac_pkg::cbac_bus_ctl_t I_BUS_CTL,
    input wire cbac_pkg::cbac_rd_req_t  I_RD_REQ,
    input wire logic                    I_WR_REQ,
    input wire logic                    I_CMP_WR,
    input wire logic                    I_FLOAT_ALL_N,
    input wire logic                    O_ALE,
    input wire logic                    O_BUS_OE,
    input wire logic [1:0]              O_DUAL_PIN,
    input wire logic [1:0]              O_DUAL_OE,
    input wire logic                    O_MGNT_OE,
    input wire logic                    O_BUS_REF_CLK,
    input wire logic                    O_BUS_REF_CLK_OE,
    input wire logic                    O_MATCH_N,
    input wire logic                    O_MATCH_OE
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    sequence s_low3; !O_MATCH_N [*3]; endsequence
    property p_float; !I_FLOAT_ALL_N |-> !(O_BUS_OE | O_MGNT_OE | O_BUS_REF_CLK_OE | O_MATCH_OE | (|O_DUAL_OE));
    endproperty
    a_float: assert property (p_float) else $error("driven while floated");
    property p_issue; $rose(O_ALE) |-> $past(I_WR_REQ || I_RD_REQ.uncached || !I_RD_REQ.hit); endproperty
    a_issue: assert property (p_issue) else $error("bus cycle for a cache hit");
    property p_match; $fell(O_MATCH_N) |-> s_low3; endproperty
    a_match: assert property (p_match) else $error("match pulse too short");
    property p_hold; I_BUS_CTL.match_hold && !O_MATCH_N && !I_CMP_WR && !$past(I_CMP_WR) |=> !O_MATCH_N; endproperty
    a_hold: assert property (p_hold) else $error("held match released early");
    property p_sel; I_BUS_CTL.brcond_in && $past(I_BUS_CTL.brcond_in) |-> O_DUAL_OE == 2'h0; endproperty
    a_sel: assert property (p_sel) else $error("dual pin driven as input");
    property p_ref; $past(I_NRST) |-> O_BUS_REF_CLK != $past(O_BUS_REF_CLK); endproperty
    a_ref: assert property (p_ref) else $error("reference clock not halved");
    // Strobe waits a full clock so address and controls settle
    property p_strb; $fell(O_DUAL_PIN[1]) && O_DUAL_OE[1] |-> !$past(O_ALE) && !$past(O_ALE, 2); endproperty
    a_strb: assert property (p_strb) else $error("peripheral strobe early");
    property p_win; $fell(O_DUAL_PIN[0]) && O_DUAL_OE[0] |-> $past(O_ALE, 2); endproperty
    a_win: assert property (p_win) else $error("window start off by a cycle");
endmodule
bind cbac_top cbac_top_props i_props (.*);

// File: verification/test_cbac_top.sv
// Bench of the auxiliary bus control block
`timescale 1ns/10ps
module test_cbac_top;
    logic I_CLK_SYS = 0, I_NRST = 0, I_CFG_WR = 0, I_WR_REQ = 0, I_FLOAT_ALL_N = 1, I_MREQ_N = 1, I_CMP_WR = 0;
    logic I_RDCEN_N, I_ACK_N, O_REQ_READY, O_HIT_DONE, O_ALE, O_RD_N, O_WR_N, O_BURST_N, O_TRACE, O_BUS_OE;
    logic O_MGNT_N, O_MGNT_OE, O_BUS_REF_CLK, O_BUS_REF_CLK_OE, O_MATCH_N, O_MATCH_OE, pend = 0, pv = 0;
    logic [3:0] I_RESET_MODES = 0, O_RESET_MODES, wt = 0, rm;
    logic [4:0] O_BEATS;
    logic [1:0] I_DUAL_PIN, O_DUAL_PIN, O_DUAL_OE, O_BRCOND, ext = 2'h3;
    logic [2:0] I_SYNC_IRQ_N = 3'h7, I_DIRECT_IRQ_N = 3'h7;
    logic [5:0] O_IRQ_N;
    logic [31:0] I_TIMER = 0, I_COMPARE = 32'h10;
    logic [10:0] q[$], e;
    cbac_pkg::cbac_bus_ctl_t I_BUS_CTL = '0;
    cbac_pkg::cbac_rd_req_t I_RD_REQ = '0;
    cbac_pkg::cbac_size_t s;
    int errors = 0, samples_checked = 0, cyc = 0, n, k;
    assign I_DUAL_PIN = (O_DUAL_OE & O_DUAL_PIN) | (~O_DUAL_OE & ext);
    cbac_top i_dut (.*);
    cbac_mem_model i_mem (.i_clk(I_CLK_SYS), .i_rd_n(O_RD_N), .i_wr_n(O_WR_N), .i_beats(O_BEATS), .i_wait(wt),
        .o_rdcen_n(I_RDCEN_N), .o_ack_n(I_ACK_N));
    always #50 I_CLK_SYS = ~I_CLK_SYS;
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] v);
        samples_checked++;
        if (x !== v) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, x, v);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge I_CLK_SYS);
        #1;
    endtask
    always @(posedge I_CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    function automatic logic [4:0] f_beats(cbac_pkg::cbac_port_t p, cbac_pkg::cbac_size_t z, logic blk);
        logic [4:0] w;
        w = (p == cbac_pkg::CBAC_PORT_32) ? 5'h01 : (p == cbac_pkg::CBAC_PORT_16) ? 5'h02 : 5'h04;
        if (blk) return w << 2;
        if (z == cbac_pkg::CBAC_SZ_WORD) return w;
        return (p == cbac_pkg::CBAC_PORT_8) ? 5'(z) + 5'h01 : 5'h01;
    endfunction
    // Note layout: kind(0 hit,1 write,2 read), instr, miss, burst_n, spare, beats
    task automatic xfer(input logic w, input logic ins, input logic unc, input logic hit);
        logic blk;
        blk = !unc && (ins || I_BUS_CTL.dcache_quad);
        if (w) q.push_back(11'h200);
        else if (hit && !unc) q.push_back(11'h000);
        else q.push_back({2'h2, ins, !unc, !blk, 1'b0, f_beats(I_BUS_CTL.port_size, s, blk)});
        wt = 4'($urandom_range(3));
        I_WR_REQ = w;
        I_RD_REQ = {!w, ins, unc, hit, s};
        do @(negedge I_CLK_SYS); while (O_REQ_READY !== 1'b1);
        tick(1);
        I_WR_REQ = 0;
        I_RD_REQ = '0;
        tick(3);
        while (O_RD_N !== 1'b1 || O_WR_N !== 1'b1) tick(1);
        tick(3);
    endtask
    always @(negedge I_CLK_SYS) begin
        if (pend) chk("trace_rest", pv, O_TRACE);
        pend = 0;
        if (O_ALE === 1'b1 || O_HIT_DONE === 1'b1) begin
            e = q.pop_front();
            chk("ale", e[10:9] != 0, O_ALE);
            chk("rd_n", e[10:9] != 2, O_RD_N);
            if (e[10:9] == 2) begin
                chk("trace_addr", e[7], O_TRACE);
                chk("burst_n", e[6], O_BURST_N);
                chk("beats", e[4:0], O_BEATS);
                pend = 1;
                pv = e[8];
            end
        end
    end
    initial begin
        void'($urandom(32'h91C3FE52));
        rm = 4'($urandom);
        I_RESET_MODES = rm;
        repeat (6) @(posedge I_CLK_SYS);
        #1 I_NRST = 1;
        I_RESET_MODES = ~rm;
        tick(2);
        chk("modes", rm, O_RESET_MODES);
        I_BUS_CTL.strobe_ctl = 2'h3;
        I_BUS_CTL.window_ctl = 2'h3;
        s = cbac_pkg::CBAC_SZ_WORD;
        xfer(0, 1, 0, 0);
        chk("dual_oe", 0, O_DUAL_OE);
        I_CFG_WR = 1;
        tick(1);
        I_CFG_WR = 0;
        for (n = 0; n < 40; n++) begin
            I_BUS_CTL = {1'b0, 7'($urandom), cbac_pkg::cbac_port_t'($urandom_range(2))};
            s = cbac_pkg::cbac_size_t'($urandom_range(3));
            if (I_BUS_CTL.port_size != cbac_pkg::CBAC_PORT_8 && s == cbac_pkg::CBAC_SZ_TRI) s = cbac_pkg::CBAC_SZ_WORD;
            e = 11'($urandom);
            if (!e[1]) s = cbac_pkg::CBAC_SZ_WORD;
            xfer($urandom_range(4) == 0, e[0], e[1], e[2]);
        end
        I_BUS_CTL.brcond_in = 1;
        for (n = 1; n < 3; n++) begin
            ext = 2'(n);
            tick(8);
            chk("brcond", 8'(n), O_BRCOND);
        end
        I_BUS_CTL.brcond_in = 0;
        repeat (3) begin
            {I_DIRECT_IRQ_N, I_SYNC_IRQ_N} = 6'($urandom);
            tick(8);
            chk("irq", {I_DIRECT_IRQ_N, I_SYNC_IRQ_N}, O_IRQ_N);
        end
        I_MREQ_N = 0;
        tick(8);
        chk("grant", 0, {O_MGNT_N, O_BUS_OE});
        I_MREQ_N = 1;
        tick(8);
        chk("reclaim", 3, {O_MGNT_N, O_BUS_OE});
        I_FLOAT_ALL_N = 0;
        #10 chk("float", 0, {O_MGNT_OE, O_BUS_REF_CLK_OE, O_MATCH_OE});
        tick(1);
        I_FLOAT_ALL_N = 1;
        // A held match would mask a second pulse, so the plain case runs first
        for (n = 0; n < 2; n++) begin
            I_BUS_CTL.match_hold = n[0];
            I_TIMER = I_COMPARE;
            k = 0;
            repeat (12) begin
                tick(1);
                I_TIMER = I_COMPARE + 1;
                k += (O_MATCH_N === 1'b0);
            end
            chk("match_low", n ? 12 : 1, n ? k : (k >= 3));
            I_CMP_WR = 1;
            tick(1);
            I_CMP_WR = 0;
            tick(3);
            chk("match_end", 1, O_MATCH_N);
        end
        complete_run();
    end
endmodule
